// >>> core/ind_aux_port.sv
// indicator and auxiliary control port logic
// Functional notes
// - pulse command indicator on each command for this node only.
// - troubleshooting option holds command indicator steadily on.
// - active preset flashes preset-number bursts, pause between bursts.
// - preset active only while settings match; change stops flashing.
// - link indicator lit on link, flashing on any traffic.
// - speed indicator lit only at 100 megabit link.
// - primary audio port failure enables secondary port.
// - audio port indicator on while in use, blinks when conductor.
// - loss of network audio selects local balanced inputs.
// - override on balanced inputs switches source to it.
// - aux output modes manual, error, preset; manual follows command.
// - error mode asserts aux output on any enabled source error.
// - preset mode drives aux output with preset flash pattern.
// - output inversion applies in manual and error modes only.
// - no-action aux input mode keeps input state readable.
// - mute modes mute channel one, two or both while active.
// - power modes disable channel one, two or both while active.
// - cycle mode steps preset on active-going aux input edge.
// - at upper preset bound, next event wraps to lower bound.
// - high aux input active by default; inversion makes low active.
`timescale 1ns/10ps
module ind_aux_port
	import ind_aux_pkg::*;
(
	input  wire logic                clock,
	input  wire logic                rst_n,
	input  wire timing_t             timing,
	input  wire logic                cmd_rx,
	input  wire logic                cmd_for_me,
	input  wire logic                trouble_on,
	input  wire logic [PRESET_W-1:0] preset_num,
	input  wire logic                preset_load,
	input  wire logic                setting_change,
	input  wire logic                link_up,
	input  wire logic                net_traffic,
	input  wire logic                speed_100,
	input  wire logic                pri_fail,
	input  wire logic [1:0]          port_in_use,
	input  wire logic                conductor,
	input  wire logic                net_audio_lost,
	input  wire logic                override_det,
	input  wire aux_out_mode_t       aux_out_mode,
	input  wire logic                aux_out_cmd,
	input  wire logic                aux_out_inv,
	input  wire err_src_t            err_state,
	input  wire err_src_t            err_enable,
	input  wire aux_in_mode_t        aux_in_mode,
	input  wire logic                aux_in_inv,
	input  wire logic                aux_in_raw,
	input  wire logic [PRESET_W-1:0] preset_min,
	input  wire logic [PRESET_W-1:0] preset_max,
	output logic                     cmd_led_ff,
	output logic                     preset_led_ff,
	output logic                     link_led_ff,
	output logic                     speed_led_ff,
	output logic                     sec_port_en_ff,
	output logic [1:0]               audio_led_ff,
	output logic                     use_local_ff,
	output logic                     aux_out_ff,
	output logic                     aux_in_state_ff,
	output chan_ctl_t                chan_ctl_ff,
	output logic                     preset_step_ff,
	output logic [PRESET_W-1:0]      preset_sel_ff,
	output logic                     preset_active_ff
);

	// ****************************************
	// command activity indicator
	// ****************************************
	logic [CNT_W-1:0] pulse_cnt_ff;

	// only commands addressed here retrigger the pulse; broadcast traffic is link-only
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			pulse_cnt_ff <= CNT_ZERO;
			cmd_led_ff   <= 1'b0;
		end else begin
			if (cmd_rx && cmd_for_me)
				pulse_cnt_ff <= timing.pulse;
			else if (pulse_cnt_ff != CNT_ZERO)
				pulse_cnt_ff <= pulse_cnt_ff - 24'h000001;
			cmd_led_ff <= trouble_on | (cmd_rx & cmd_for_me) | (pulse_cnt_ff != CNT_ZERO);
		end
	end

	// ****************************************
	// preset state and flash pattern
	// ****************************************
	typedef enum logic [1:0] {FL_IDLE, FL_ON, FL_OFF, FL_PAUSE} flash_state_t;
	flash_state_t         fl_state_ff;
	logic [CNT_W-1:0]     fl_cnt_ff;
	logic [PRESET_W-1:0]  fl_left_ff;
	logic                 cyc_event;

	// a change clears the active flag; a load or a cycle step in the same cycle wins
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			preset_active_ff <= 1'b0;
			preset_sel_ff    <= PRESET_RST;
		end else if (cyc_event) begin
			preset_sel_ff    <= (preset_sel_ff >= preset_max || preset_sel_ff < preset_min)
				? preset_min : preset_sel_ff + 4'h1;
			preset_active_ff <= 1'b1;
		end else if (preset_load) begin
			preset_sel_ff    <= preset_num;
			preset_active_ff <= 1'b1;
		end else if (setting_change) begin
			preset_active_ff <= 1'b0;
		end
	end

	// burst of preset_sel flashes, then pause; restart from idle whenever inactive
	always_ff @(posedge clock) begin
		if (!rst_n || !preset_active_ff) begin
			fl_state_ff <= FL_IDLE;
			fl_cnt_ff   <= CNT_ZERO;
			fl_left_ff  <= 4'h0;
		end else if (fl_cnt_ff != CNT_ZERO) begin
			fl_cnt_ff <= fl_cnt_ff - 24'h000001;
		end else begin
			case (fl_state_ff)
				FL_IDLE, FL_PAUSE: begin
					// preset zero has no flashes, so only the pause repeats
					if (preset_sel_ff == 4'h0) begin
						fl_state_ff <= FL_PAUSE;
						fl_cnt_ff   <= timing.pause;
					end else begin
						fl_state_ff <= FL_ON;
						fl_cnt_ff   <= timing.flash_on;
						fl_left_ff  <= preset_sel_ff;
					end
				end
				FL_ON: begin
					fl_state_ff <= FL_OFF;
					fl_cnt_ff   <= timing.flash_off;
					fl_left_ff  <= fl_left_ff - 4'h1;
				end
				FL_OFF: begin
					if (fl_left_ff == 4'h0) begin
						fl_state_ff <= FL_PAUSE;
						fl_cnt_ff   <= timing.pause;
					end else begin
						fl_state_ff <= FL_ON;
						fl_cnt_ff   <= timing.flash_on;
					end
				end
				default: fl_state_ff <= FL_IDLE;
			endcase
		end
	end

	logic flash_lvl;
	assign flash_lvl = (fl_state_ff == FL_ON);

	always_ff @(posedge clock) begin
		if (!rst_n) preset_led_ff <= 1'b0;
		else        preset_led_ff <= flash_lvl;
	end

	// ****************************************
	// network indicators and failover
	// ****************************************
	logic [CNT_W-1:0] blink_cnt_ff;
	logic             blink_ph_ff;

	// one shared blink clock for traffic and conductor indications
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			blink_cnt_ff <= CNT_ZERO;
			blink_ph_ff  <= 1'b0;
		end else if (blink_cnt_ff >= timing.blink) begin
			blink_cnt_ff <= CNT_ZERO;
			blink_ph_ff  <= ~blink_ph_ff;
		end else begin
			blink_cnt_ff <= blink_cnt_ff + 24'h000001;
		end
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			link_led_ff  <= 1'b0;
			speed_led_ff <= 1'b0;
		end else begin
			link_led_ff  <= link_up & ~(net_traffic & blink_ph_ff);
			speed_led_ff <= link_up & speed_100;
		end
	end

	genvar gp;
	generate
		for (gp = 0; gp < 2; gp++) begin : g_port
			always_ff @(posedge clock) begin
				if (!rst_n) audio_led_ff[gp] <= 1'b0;
				else        audio_led_ff[gp] <= port_in_use[gp] & (~conductor | blink_ph_ff);
			end
		end
	endgenerate

	// secondary stays enabled once primary failed until reset; local source follows status
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			sec_port_en_ff <= 1'b0;
			use_local_ff   <= 1'b0;
		end else begin
			if (pri_fail) sec_port_en_ff <= 1'b1;
			use_local_ff <= net_audio_lost | override_det;
		end
	end

	// ****************************************
	// auxiliary output
	// ****************************************
	logic err_any;
	assign err_any = |(err_state & err_enable);

	always_ff @(posedge clock) begin
		if (!rst_n) aux_out_ff <= 1'b0;
		else begin
			case (aux_out_mode)
				AUXO_MANUAL: aux_out_ff <= aux_out_cmd ^ aux_out_inv;
				AUXO_ERROR:  aux_out_ff <= err_any ^ aux_out_inv;
				AUXO_PRESET: aux_out_ff <= flash_lvl;
				default:     aux_out_ff <= 1'b0;
			endcase
		end
	end

	// ****************************************
	// auxiliary input
	// ****************************************
	logic deb_lvl;
	logic deb_rise;
	logic deb_fall;

	aux_in_filter u_filter (
		.clock      (clock),
		.rst_n      (rst_n),
		.raw_in     (aux_in_raw),
		.deb_cycles (timing.debounce),
		.level      (deb_lvl),
		.rise       (deb_rise),
		.fall       (deb_fall)
	);

	logic act;
	assign act       = deb_lvl ^ aux_in_inv;
	assign cyc_event = (aux_in_mode == AUXI_CYCLE) && (aux_in_inv ? deb_fall : deb_rise);

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			aux_in_state_ff <= 1'b0;
			chan_ctl_ff     <= '0;
			preset_step_ff  <= 1'b0;
		end else begin
			aux_in_state_ff      <= deb_lvl;
			preset_step_ff       <= cyc_event;
			chan_ctl_ff.mute1    <= act && (aux_in_mode == AUXI_MUTE1 ||
				aux_in_mode == AUXI_MUTE_BOTH);
			chan_ctl_ff.mute2    <= act && (aux_in_mode == AUXI_MUTE2 ||
				aux_in_mode == AUXI_MUTE_BOTH);
			chan_ctl_ff.pwr_off1 <= act && (aux_in_mode == AUXI_PWR1 ||
				aux_in_mode == AUXI_PWR_BOTH);
			chan_ctl_ff.pwr_off2 <= act && (aux_in_mode == AUXI_PWR2 ||
				aux_in_mode == AUXI_PWR_BOTH);
		end
	end

	// ****************************************
	// assertions
	// ****************************************
	property p_cmd_led;
		@(posedge clock) disable iff (!rst_n) (cmd_rx && cmd_for_me) |=> cmd_led_ff;
	endproperty
	a_cmd_led: assert property (p_cmd_led) else $error("cmd led missed");

	property p_trouble;
		@(posedge clock) disable iff (!rst_n) trouble_on |=> cmd_led_ff;
	endproperty
	a_trouble: assert property (p_trouble) else $error("trouble not steady");

	property p_inactive;
		@(posedge clock) disable iff (!rst_n)
			(setting_change && !preset_load && !cyc_event) |=> ##2 !preset_led_ff;
	endproperty
	a_inactive: assert property (p_inactive) else $error("flash after change");

	property p_speed;
		@(posedge clock) disable iff (!rst_n) speed_led_ff |-> $past(link_up && speed_100);
	endproperty
	a_speed: assert property (p_speed) else $error("speed led wrong");

	property p_sec;
		@(posedge clock) disable iff (!rst_n) pri_fail |=> sec_port_en_ff;
	endproperty
	a_sec: assert property (p_sec) else $error("secondary not enabled");

	property p_local;
		@(posedge clock) disable iff (!rst_n) (net_audio_lost || override_det) |=> use_local_ff;
	endproperty
	a_local: assert property (p_local) else $error("local source missed");

	property p_manual;
		@(posedge clock) disable iff (!rst_n)
			(aux_out_mode == AUXO_MANUAL) |=> aux_out_ff == $past(aux_out_cmd ^ aux_out_inv);
	endproperty
	a_manual: assert property (p_manual) else $error("manual aux out wrong");

	property p_error;
		@(posedge clock) disable iff (!rst_n)
			(aux_out_mode == AUXO_ERROR) |=> aux_out_ff == $past(err_any ^ aux_out_inv);
	endproperty
	a_error: assert property (p_error) else $error("error aux out wrong");

	property p_wrap;
		@(posedge clock) disable iff (!rst_n)
			(cyc_event && preset_sel_ff >= preset_max) |=> preset_sel_ff == $past(preset_min);
	endproperty
	a_wrap: assert property (p_wrap) else $error("preset wrap wrong");

	property p_mute_both;
		@(posedge clock) disable iff (!rst_n)
			(aux_in_mode == AUXI_MUTE_BOTH && act) |=> chan_ctl_ff.mute1 && chan_ctl_ff.mute2;
	endproperty
	a_mute_both: assert property (p_mute_both) else $error("mute both missed");

	c_cycle:   cover property (@(posedge clock) disable iff (!rst_n) cyc_event);
	c_flash:   cover property (@(posedge clock) disable iff (!rst_n) fl_state_ff == FL_PAUSE);
	c_err_out: cover property (@(posedge clock) disable iff (!rst_n)
		aux_out_mode == AUXO_ERROR && aux_out_ff);

endmodule

// >>> core/ind_aux_pkg.sv
// package: constants, modes and carrier structs for the indicator and aux port block
package ind_aux_pkg;

	// ****************************************
	// widths and reset values
	// ****************************************
	localparam int unsigned PRESET_W   = 4;
	localparam int unsigned CNT_W      = 24;
	localparam int unsigned DEB_W      = 16;
	localparam logic [PRESET_W-1:0] PRESET_RST = 4'h1;
	localparam logic [CNT_W-1:0]    CNT_ZERO   = 24'h000000;
	localparam logic [DEB_W-1:0]    DEB_ZERO   = 16'h0000;
	// default phase lengths in clock cycles (4 ns each)
	localparam logic [CNT_W-1:0] DEF_FLASH_ON  = 24'h2faf08;
	localparam logic [CNT_W-1:0] DEF_FLASH_OFF = 24'h2faf08;
	localparam logic [CNT_W-1:0] DEF_PAUSE     = 24'hbebc20;
	localparam logic [CNT_W-1:0] DEF_PULSE     = 24'h1312d0;
	localparam logic [CNT_W-1:0] DEF_BLINK     = 24'h5f5e10;
	localparam logic [DEB_W-1:0] DEF_DEBOUNCE  = 16'hc350;

	// ****************************************
	// modes
	// ****************************************
	typedef enum logic [1:0] {AUXO_MANUAL, AUXO_ERROR, AUXO_PRESET} aux_out_mode_t;
	typedef enum logic [2:0] {
		AUXI_NONE, AUXI_MUTE1, AUXI_MUTE2, AUXI_MUTE_BOTH,
		AUXI_PWR1, AUXI_PWR2, AUXI_PWR_BOTH, AUXI_CYCLE
	} aux_in_mode_t;

	// ****************************************
	// carriers
	// ****************************************
	typedef struct packed {
		logic [CNT_W-1:0] flash_on;
		logic [CNT_W-1:0] flash_off;
		logic [CNT_W-1:0] pause;
		logic [CNT_W-1:0] pulse;
		logic [CNT_W-1:0] blink;
		logic [DEB_W-1:0] debounce;
	} timing_t;

	typedef struct packed {
		logic thermal;
		logic clip;
		logic load;
		logic amp_fault;
		logic line_volt;
	} err_src_t;

	typedef struct packed {
		logic mute1;
		logic mute2;
		logic pwr_off1;
		logic pwr_off2;
	} chan_ctl_t;

endpackage

// >>> core/aux_in_filter.sv
// debounce filter for the auxiliary input, with synchroniser and edge pulses
`timescale 1ns/10ps
module aux_in_filter
	import ind_aux_pkg::*;
(
	input  wire logic             clock,
	input  wire logic             rst_n,
	input  wire logic             raw_in,
	input  wire logic [DEB_W-1:0] deb_cycles,
	output logic                  level,
	output logic                  rise,
	output logic                  fall
);

	logic             sync1_ff;
	logic             sync2_ff;
	logic             level_ff;
	logic [DEB_W-1:0] cnt_ff;

	// two-stage synchroniser; first stage feeds only the second
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			sync1_ff <= 1'b0;
			sync2_ff <= 1'b0;
		end else begin
			sync1_ff <= raw_in;
			sync2_ff <= sync1_ff;
		end
	end

	// the level changes only after the input differs from it for deb_cycles + 1 cycles in a row, so bounce makes one edge
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			level_ff <= 1'b0;
			cnt_ff   <= DEB_ZERO;
		end else if (sync2_ff == level_ff) begin
			cnt_ff <= DEB_ZERO;
		end else if (cnt_ff >= deb_cycles) begin
			level_ff <= sync2_ff;
			cnt_ff   <= DEB_ZERO;
		end else begin
			cnt_ff <= cnt_ff + 16'h0001;
		end
	end

	// previous level, for one-cycle edge pulses
	logic prev_ff;
	always_ff @(posedge clock) begin
		if (!rst_n) prev_ff <= 1'b0;
		else        prev_ff <= level_ff;
	end

	assign level = level_ff;
	assign rise  = level_ff & ~prev_ff;
	assign fall  = ~level_ff & prev_ff;

endmodule

// >>> tb/switch_contact_model.sv
// external switch contact model that chatters on each change of position
`timescale 1ns/10ps
module switch_contact_model (
	input  wire logic clock,
	input  wire logic closed,
	output logic      contact_out
);
	logic [1:0] bounce_ff;
	logic       settled_ff;

	initial begin
		contact_out = 1'b0;
		bounce_ff   = 2'h0;
		settled_ff  = 1'b0;
	end

	// ****************************************
	// contact chatter
	// ****************************************
	// runs of one cycle stay shorter than any sane debounce, so only the
	// final position may count as one closure or one release
	always @(posedge clock) begin
		if (closed != settled_ff) begin
			settled_ff  <= closed;
			bounce_ff   <= 2'h3;
			contact_out <= closed;
		end else if (bounce_ff != 2'h0) begin
			bounce_ff   <= bounce_ff - 2'h1;
			contact_out <= bounce_ff[0] ? ~settled_ff : settled_ff;
		end else begin
			contact_out <= settled_ff;
		end
	end
endmodule

// >>> tb/tb_ind_aux_port.sv
// self-checking testbench for the indicator and auxiliary port block
`timescale 1ns/10ps
module tb_ind_aux_port
	import ind_aux_pkg::*;
;
	logic                clock = 1'b0;
	logic                rst_n = 1'b0;
	timing_t             timing;
	logic                cmd_rx, cmd_for_me, trouble_on, preset_load, setting_change;
	logic                link_up, net_traffic, speed_100, pri_fail, conductor;
	logic                net_audio_lost, override_det, aux_out_cmd, aux_out_inv;
	logic                aux_in_inv, aux_in_raw, closed, sticky, prev;
	logic [1:0]          port_in_use, audio_led_ff;
	logic [PRESET_W-1:0] preset_num, preset_min, preset_max, preset_sel_ff;
	aux_out_mode_t       aux_out_mode;
	aux_in_mode_t        aux_in_mode;
	err_src_t            err_state, err_enable;
	chan_ctl_t           chan_ctl_ff;
	logic                cmd_led_ff, preset_led_ff, link_led_ff, speed_led_ff, sec_port_en_ff;
	logic                use_local_ff, aux_out_ff, aux_in_state_ff, preset_step_ff;
	logic                preset_active_ff;
	logic [31:0]         seed = 32'h00008a86;
	int                  miscompares = 0;
	int                  checked = 0;
	int                  st, c0, c1, c2, c3, sel_m;
	int                  sel_q[$];

	// clock at 4 ns period
	always #2 clock = ~clock;

	ind_aux_port u_ind_aux_port (
		.clock, .rst_n, .timing, .cmd_rx, .cmd_for_me, .trouble_on, .preset_num,
		.preset_load, .setting_change, .link_up, .net_traffic, .speed_100, .pri_fail,
		.port_in_use, .conductor, .net_audio_lost, .override_det, .aux_out_mode,
		.aux_out_cmd, .aux_out_inv, .err_state, .err_enable, .aux_in_mode, .aux_in_inv,
		.aux_in_raw, .preset_min, .preset_max, .cmd_led_ff, .preset_led_ff, .link_led_ff,
		.speed_led_ff, .sec_port_en_ff, .audio_led_ff, .use_local_ff, .aux_out_ff,
		.aux_in_state_ff, .chan_ctl_ff, .preset_step_ff, .preset_sel_ff, .preset_active_ff
	);

	switch_contact_model u_switch_contact_model (
		.clock       (clock),
		.closed      (closed),
		.contact_out (aux_in_raw)
	);

	// ****************************************
	// helpers
	// ****************************************
	function automatic logic [31:0] xs(input logic [31:0] v);
		logic [31:0] r;
		r = v ^ (v << 13);
		r = r ^ (r >> 17);
		return r ^ (r << 5);
	endfunction

	// expected channel controls for an input mode and an active level
	function automatic chan_ctl_t exp_chan(input int m, input logic a);
		chan_ctl_t c;
		c.mute1    = a & (m == 1 || m == 3);
		c.mute2    = a & (m == 2 || m == 3);
		c.pwr_off1 = a & (m == 4 || m == 6);
		c.pwr_off2 = a & (m == 5 || m == 6);
		return c;
	endfunction

	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			miscompares++;
			$display("Error %s expected %0h seen %0h", nm, exp, seen);
		end
	endtask

	task automatic nx(input int n);
		repeat (n) @(posedge clock);
		@(negedge clock);
	endtask

	// move the switch and count step pulses over a window longer than the filter delay
	task automatic sw(input logic c, output int s);
		@(posedge clock);
		closed <= c;
		s = 0;
		repeat (30) begin
			@(negedge clock);
			if (preset_step_ff === 1'b1) s++;
		end
		chk("aux_in_state", aux_in_state_ff, c);
	endtask

	task automatic print_verdict();
		$display("checked %0d miscompares %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	// ****************************************
	// main sequence
	// ****************************************
	initial begin
		{cmd_rx, cmd_for_me, trouble_on, preset_load, setting_change} = 5'h00;
		{link_up, net_traffic, speed_100, pri_fail, conductor} = 5'h00;
		{net_audio_lost, override_det, aux_out_cmd, aux_out_inv, aux_in_inv} = 5'h00;
		{closed, sticky, port_in_use, err_state, err_enable} = 14'h0000;
		timing = '{flash_on: 24'h000004, flash_off: 24'h000004, pause: 24'h00000a,
			pulse: 24'h000006, blink: 24'h000005, debounce: 16'h0003};
		aux_out_mode = AUXO_MANUAL;
		aux_in_mode  = AUXI_NONE;
		preset_num   = 4'h3;
		preset_min   = 4'h2;
		preset_max   = 4'h4;
		nx(9);
		chk("sel_rst", preset_sel_ff, 4'h1);
		chk("outs_rst", {cmd_led_ff, preset_led_ff, link_led_ff, speed_led_ff, sec_port_en_ff,
			audio_led_ff, use_local_ff, aux_out_ff, chan_ctl_ff, preset_step_ff,
			preset_active_ff}, 32'h0);
		@(posedge clock);
		rst_n <= 1'b1;
		// a command for another node leaves the indicator dark
		@(posedge clock);
		cmd_rx <= 1'b1;
		@(posedge clock);
		cmd_rx <= 1'b0;
		nx(3);
		chk("cmd_led_foreign", cmd_led_ff, 1'b0);
		@(posedge clock);
		cmd_rx     <= 1'b1;
		cmd_for_me <= 1'b1;
		@(posedge clock);
		cmd_rx <= 1'b0;
		@(negedge clock);
		chk("cmd_led_on", cmd_led_ff, 1'b1);
		nx(5);
		chk("cmd_led_hold", cmd_led_ff, 1'b1);
		nx(4);
		chk("cmd_led_off", cmd_led_ff, 1'b0);
		@(posedge clock);
		trouble_on <= 1'b1;
		nx(12);
		chk("cmd_led_trouble", cmd_led_ff, 1'b1);
		@(posedge clock);
		trouble_on <= 1'b0;
		// random network levels, failover sticks once seen
		for (int i = 0; i < 10; i++) begin
			seed = xs(seed);
			@(posedge clock);
			{speed_100, pri_fail, net_audio_lost, override_det, port_in_use, link_up} <= seed[6:0];
			sticky = sticky | seed[5];
			nx(2);
			chk("link_led", link_led_ff, link_up);
			chk("speed_led", speed_led_ff, speed_100 & link_up);
			chk("sec_port", sec_port_en_ff, sticky);
			chk("audio_led", audio_led_ff, port_in_use);
			chk("use_local", use_local_ff, net_audio_lost | override_det);
		end
		// traffic flashes the link indicator, conductor blinks the port indicator
		@(posedge clock);
		{link_up, net_traffic, conductor, port_in_use} <= 5'h1f;
		{c0, c1, c2, c3} = '0;
		repeat (40) begin
			@(negedge clock);
			if (link_led_ff === 1'b0) c0++;
			if (link_led_ff === 1'b1) c1++;
			if (audio_led_ff[0] === 1'b0) c2++;
			if (audio_led_ff[0] === 1'b1) c3++;
		end
		chk("link_flash", (c0 > 0) && (c1 > 0), 1'b1);
		chk("audio_blink", (c2 > 0) && (c3 > 0), 1'b1);
		@(posedge clock);
		{net_traffic, conductor} <= 2'h0;
		// manual then error reporting, with random inversion
		for (int i = 0; i < 14; i++) begin
			seed = xs(seed);
			@(posedge clock);
			aux_out_mode <= (i < 4) ? AUXO_MANUAL : AUXO_ERROR;
			{aux_out_inv, aux_out_cmd, err_enable, err_state} <= seed[11:0];
			nx(2);
			chk("aux_out", aux_out_ff, ((i < 4) ? seed[10] : |(seed[4:0] & seed[9:5])) ^ seed[11]);
		end
		// preset three flashes three times a period, inversion ignored
		@(posedge clock);
		aux_out_mode <= AUXO_PRESET;
		aux_out_inv  <= 1'b1;
		preset_load  <= 1'b1;
		@(posedge clock);
		preset_load <= 1'b0;
		nx(4);
		chk("active", preset_active_ff, 1'b1);
		chk("sel_load", preset_sel_ff, 4'h3);
		prev = preset_led_ff;
		{c0, c1} = '0;
		repeat (41) begin
			@(negedge clock);
			if (preset_led_ff === 1'b1 && prev === 1'b0) c0++;
			if (aux_out_ff !== preset_led_ff) c1++;
			prev = preset_led_ff;
		end
		chk("flash_count", c0, 3);
		chk("aux_flash", c1, 0);
		@(posedge clock);
		setting_change <= 1'b1;
		@(posedge clock);
		setting_change <= 1'b0;
		nx(1);
		chk("inactive", preset_active_ff, 1'b0);
		c0 = 0;
		repeat (50) begin
			@(negedge clock);
			if (preset_led_ff !== 1'b0) c0++;
		end
		chk("flash_stop", c0, 0);
		// every level mode, both polarities
		for (int i = 0; i < 14; i++) begin
			@(posedge clock);
			aux_in_mode <= aux_in_mode_t'(i / 2);
			aux_in_inv  <= i[0];
			sw(1'b1, st);
			chk("chan_on", chan_ctl_ff, exp_chan(i / 2, ~i[0]));
			chk("no_step", st, 0);
			sw(1'b0, st);
			chk("chan_off", chan_ctl_ff, exp_chan(i / 2, i[0]));
		end
		// cycling with wrap, rising edge then falling edge when inverted
		@(posedge clock);
		aux_in_mode <= AUXI_CYCLE;
		aux_in_inv  <= 1'b0;
		sel_m = 3;
		for (int i = 0; i < 6; i++) begin
			@(posedge clock);
			aux_in_inv <= (i >= 4);
			sw(!i[0], st);
			if ((i >= 4) ? i[0] : !i[0]) sel_m = (sel_m >= 4) ? 2 : sel_m + 1;
			sel_q.push_back(sel_m);
			chk("steps", st, ((i >= 4) ? i[0] : !i[0]));
			chk("sel_cycle", preset_sel_ff, sel_q.pop_front());
		end
		// preset zero flashes nothing; a step from below the range lands on its lower bound
		@(posedge clock);
		setting_change <= 1'b1;
		@(posedge clock);
		setting_change <= 1'b0;
		preset_num     <= 4'h0;
		preset_load    <= 1'b1;
		@(posedge clock);
		preset_load <= 1'b0;
		nx(1);
		c0 = 0;
		repeat (45) begin
			@(negedge clock);
			if (preset_led_ff !== 1'b0) c0++;
		end
		chk("flash_zero", c0, 0);
		chk("sel_zero", preset_sel_ff, 4'h0);
		sw(1'b1, st);
		sw(1'b0, st);
		chk("steps_low", st, 1);
		chk("sel_low", preset_sel_ff, 4'h2);
		print_verdict();
	end
endmodule
